// file: design/ahf_framer.sv
// Functional notes
// - Each value is sent as ASCII hex: two digits for bytes, four for words.
// - Every command ends with carriage return then line feed.
// - Byte waveform command: W, Z, Y, X, each followed by two digits.
// - Byte bar command: A, B, C, D, each followed by two digits.
// - Combined word command: four four-digit fields separated by commas.
// - Waveform word command: four four-digit fields separated by colons.
// - Bar word command: four four-digit fields separated by equals signs.
// - Every command carries all four channels; partial updates are never sent.
//
// Top of the ASCII hex sample framer. Takes a set of four samples plus a command
// kind and streams the text to a byte-wide transmitter with valid/ready.
// Assumes the transmitter holds tx_ready meaningful every cycle.
`timescale 1ns/1ps
module ahf_framer (
  input wire logic mclk,                 // System clock, 125 MHz
  input wire logic rstn,                 // Synchronous reset, active low
  input wire logic req_valid,            // Sample set offered
  input wire ahf_pkg::ahf_cmd_type req_cmd, // Command kind
  input wire logic [15:0] req_s0,        // First field value
  input wire logic [15:0] req_s1,        // Second field value
  input wire logic [15:0] req_s2,        // Third field value
  input wire logic [15:0] req_s3,        // Fourth field value
  output logic req_ready,                // Framer idle, set taken when valid
  input wire logic tx_ready,             // Transmitter takes a character
  output logic tx_valid,                 // Character on tx_data
  output logic [7:0] tx_data             // ASCII character
);
  import ahf_pkg::*;

  typedef enum {
    ST_IDLE,
    ST_LEAD,
    ST_DIGIT,
    ST_CONV,
    ST_CR,
    ST_LF
  } ahf_state_type;

  ahf_state_type state_reg, state_next;
  ahf_cmd_type cmd_reg, cmd_next;
  logic [63:0] vals_reg, vals_next;
  logic [1:0] field_reg, field_next;
  logic [1:0] digit_reg, digit_next;
  logic tx_valid_reg, tx_valid_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic req_ready_reg, req_ready_next;
  logic [3:0] nibble;
  logic [7:0] hex_char;
  logic is_byte;
  logic [7:0] lead_char;
  logic [1:0] last_digit;
  logic is_byte_next;
  logic lead_out_reg, lead_out_next;

  assign is_byte = (cmd_reg == AHF_CMD_BYTE_WAVE) || (cmd_reg == AHF_CMD_BYTE_BAR);
  assign is_byte_next = (cmd_next == AHF_CMD_BYTE_WAVE) || (cmd_next == AHF_CMD_BYTE_BAR);
  assign last_digit = is_byte ? 2'h1 : 2'h3;

  // Nibble of the values about to be registered, so the registered digit
  // always belongs to the current field and digit counters
  always_comb begin
    if (is_byte_next) begin
      nibble = digit_next[0] ? vals_next[59:56] : vals_next[63:60];
    end else begin
      nibble = vals_next[63:60];
    end
  end

  ahf_hex_digit u_hex (
    .mclk(mclk),
    .nibble(nibble),
    .ascii(hex_char)
  );

  // Leading letter or separator of the current field
  always_comb begin
    lead_char = AHF_CH_COMMA;
    unique case (cmd_reg)
      AHF_CMD_BYTE_WAVE: begin
        unique case (field_reg)
          2'h0: lead_char = AHF_CH_W;
          2'h1: lead_char = AHF_CH_Z;
          2'h2: lead_char = AHF_CH_Y;
          2'h3: lead_char = AHF_CH_X;
        endcase
      end
      AHF_CMD_BYTE_BAR: begin
        unique case (field_reg)
          2'h0: lead_char = AHF_CH_A;
          2'h1: lead_char = AHF_CH_B;
          2'h2: lead_char = AHF_CH_C;
          2'h3: lead_char = AHF_CH_D;
        endcase
      end
      AHF_CMD_WORD_BOTH: lead_char = AHF_CH_COMMA;
      AHF_CMD_WORD_WAVE: lead_char = AHF_CH_COLON;
      AHF_CMD_WORD_BAR: lead_char = AHF_CH_EQUAL;
      default: lead_char = AHF_CH_COMMA;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    vals_next = vals_reg;
    field_next = field_reg;
    digit_next = digit_reg;
    tx_valid_next = tx_valid_reg;
    tx_data_next = tx_data_reg;
    req_ready_next = req_ready_reg;
    lead_out_next = lead_out_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (req_valid && req_ready_reg) begin
          // Whole set latched at once so no partial update can escape
          cmd_next = req_cmd;
          if ((req_cmd == AHF_CMD_BYTE_WAVE) || (req_cmd == AHF_CMD_BYTE_BAR)) begin
            vals_next = {req_s0[7:0], req_s1[7:0], req_s2[7:0], req_s3[7:0], 32'h0};
          end else begin
            vals_next = {req_s0, req_s1, req_s2, req_s3};
          end
          field_next = 2'h0;
          digit_next = 2'h0;
          req_ready_next = 1'b0;
          state_next = ST_LEAD;
        end
      end
      ST_LEAD: begin
        // Word commands have no character before their first field
        if (!is_byte && field_reg == 2'h0) begin
          state_next = ST_CONV;
        end else begin
          tx_valid_next = 1'b1;
          tx_data_next = lead_char;
          lead_out_next = 1'b1;
          state_next = ST_DIGIT;
        end
      end
      ST_CONV: begin
        // Wait one cycle for the registered digit
        tx_valid_next = 1'b1;
        tx_data_next = hex_char;
        lead_out_next = 1'b0;
        state_next = ST_DIGIT;
      end
      ST_DIGIT: begin
        // A character is held until the transmitter takes it
        if (tx_ready) begin
          tx_valid_next = 1'b0;
          state_next = ST_CONV;
        end
      end
      ST_CR: begin
        if (tx_ready) begin
          tx_valid_next = 1'b1;
          tx_data_next = AHF_CH_LF;
          state_next = ST_LF;
        end
      end
      ST_LF: begin
        if (tx_ready) begin
          tx_valid_next = 1'b0;
          req_ready_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
    endcase
    // Digit bookkeeping: a taken hex digit advances digit/field counters
    // A flag, not a data compare: the bar letters A-D are also hex digits
    if (state_reg == ST_DIGIT && tx_ready && tx_valid_reg && !lead_out_reg) begin
      if (digit_reg == last_digit) begin
        digit_next = 2'h0;
        if (is_byte) begin
          vals_next = {vals_reg[55:0], 8'h0};
        end else begin
          vals_next = {vals_reg[59:0], 4'h0};
        end
        if (field_reg == AHF_LAST_FIELD) begin
          tx_valid_next = 1'b1;
          tx_data_next = AHF_CH_CR;
          state_next = ST_CR;
        end else begin
          field_next = field_reg + 2'h1;
          state_next = ST_LEAD;
        end
      end else begin
        digit_next = digit_reg + 2'h1;
        if (!is_byte) begin
          vals_next = {vals_reg[59:0], 4'h0};
        end
        state_next = ST_CONV;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      cmd_reg <= AHF_CMD_BYTE_WAVE;
      vals_reg <= 64'h0;
      field_reg <= 2'h0;
      digit_reg <= 2'h0;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      req_ready_reg <= 1'b1;
      lead_out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      vals_reg <= vals_next;
      field_reg <= field_next;
      digit_reg <= digit_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
      req_ready_reg <= req_ready_next;
      lead_out_reg <= lead_out_next;
    end
  end

  assign tx_valid = tx_valid_reg;
  assign tx_data = tx_data_reg;
  assign req_ready = req_ready_reg;

  // Assertions
  a_hold_until_taken: assert property (@(posedge mclk) disable iff (!rstn)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("character dropped before ready");
  a_lf_after_cr: assert property (@(posedge mclk) disable iff (!rstn)
    tx_valid && tx_ready && tx_data == AHF_CH_CR |=> tx_valid && tx_data == AHF_CH_LF)
    else $error("carriage return not followed by line feed");
  a_idle_after_lf: assert property (@(posedge mclk) disable iff (!rstn)
    tx_valid && tx_ready && tx_data == AHF_CH_LF |=> req_ready && !tx_valid)
    else $error("framer not idle after line feed");
  a_upper_hex: assert property (@(posedge mclk) disable iff (!rstn)
    state_reg == ST_CONV |=> !(tx_data inside {[8'h61:8'h66]}))
    else $error("lower case digit emitted");
  a_no_take_busy: assert property (@(posedge mclk) disable iff (!rstn)
    !req_ready |-> state_reg != ST_IDLE)
    else $error("busy flag while idle");
  a_byte_lead_w: assert property (@(posedge mclk) disable iff (!rstn)
    req_valid && req_ready && req_cmd == AHF_CMD_BYTE_WAVE |=> ##1 tx_valid && tx_data == AHF_CH_W)
    else $error("waveform byte command not led by W");
  a_byte_lead_a: assert property (@(posedge mclk) disable iff (!rstn)
    req_valid && req_ready && req_cmd == AHF_CMD_BYTE_BAR |=> ##1 tx_valid && tx_data == AHF_CH_A)
    else $error("bar byte command not led by A");
  a_word_sep: assert property (@(posedge mclk) disable iff (!rstn)
    tx_valid && cmd_reg == AHF_CMD_WORD_WAVE |-> tx_data != AHF_CH_COMMA
    && tx_data != AHF_CH_EQUAL)
    else $error("wrong separator in waveform word command");
  c_byte_cmd: cover property (@(posedge mclk) req_valid && req_ready && req_cmd == AHF_CMD_BYTE_WAVE);
  c_word_cmd: cover property (@(posedge mclk) req_valid && req_ready && req_cmd == AHF_CMD_WORD_BOTH);
  c_stall: cover property (@(posedge mclk) tx_valid && !tx_ready);

endmodule : ahf_framer

// file: design/ahf_hex_digit.sv
// Nibble to upper-case ASCII hex digit, registered.
// Assumes the caller samples the result one cycle after presenting the nibble.
`timescale 1ns/1ps
module ahf_hex_digit (
  input wire logic mclk,         // System clock
  input wire logic [3:0] nibble, // Value to convert
  output logic [7:0] ascii       // Registered ASCII digit
);
  import ahf_pkg::*;

  logic [7:0] ascii_next;

  always_comb begin
    if (nibble < 4'ha) begin
      ascii_next = AHF_CH_ZERO + {4'h0, nibble};
    end else begin
      ascii_next = AHF_CH_ALPHA_OFS + {4'h0, nibble};
    end
  end

  always_ff @(posedge mclk) begin
    ascii <= ascii_next;
  end

endmodule : ahf_hex_digit

// file: design/ahf_pkg.sv
// Package for the ASCII hex sample framer: command kinds, characters, lengths.
// Assumes one system clock; no timing constants are needed.
package ahf_pkg;

  typedef enum logic [2:0] {
    AHF_CMD_BYTE_WAVE,
    AHF_CMD_BYTE_BAR,
    AHF_CMD_WORD_BOTH,
    AHF_CMD_WORD_WAVE,
    AHF_CMD_WORD_BAR
  } ahf_cmd_type;

  localparam logic [7:0] AHF_CH_CR = 8'h0d;
  localparam logic [7:0] AHF_CH_LF = 8'h0a;
  localparam logic [7:0] AHF_CH_COMMA = 8'h2c;
  localparam logic [7:0] AHF_CH_COLON = 8'h3a;
  localparam logic [7:0] AHF_CH_EQUAL = 8'h3d;
  localparam logic [7:0] AHF_CH_W = 8'h57;
  localparam logic [7:0] AHF_CH_Z = 8'h5a;
  localparam logic [7:0] AHF_CH_Y = 8'h59;
  localparam logic [7:0] AHF_CH_X = 8'h58;
  localparam logic [7:0] AHF_CH_A = 8'h41;
  localparam logic [7:0] AHF_CH_B = 8'h42;
  localparam logic [7:0] AHF_CH_C = 8'h43;
  localparam logic [7:0] AHF_CH_D = 8'h44;
  localparam logic [7:0] AHF_CH_ZERO = 8'h30;
  localparam logic [7:0] AHF_CH_ALPHA_OFS = 8'h37;

  // Characters in one field, including its letter or separator slot
  localparam logic [2:0] AHF_BYTE_FIELD_LEN = 3'h3;
  localparam logic [2:0] AHF_WORD_FIELD_LEN = 3'h5;
  localparam logic [1:0] AHF_LAST_FIELD = 2'h3;

endpackage : ahf_pkg

// file: tb/ahf_framer_tb.sv
// Self-checking bench for the framer: builds each command text and compares it.
// Assumes the host model collects every character it takes in rx_q.
`timescale 1ns/1ps
module ahf_framer_tb;
  import ahf_pkg::*;
  logic mclk, rstn, req_valid, req_ready, tx_ready, tx_valid, slow;
  ahf_cmd_type req_cmd;
  logic [15:0] req_s0, req_s1, req_s2, req_s3;
  logic [7:0] tx_data;
  logic [7:0] exp_q[$];
  int mismatches, cmp_count;
  typedef logic [15:0] ahf_set_type [4];

  ahf_framer dut (.mclk(mclk), .rstn(rstn), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_s0(req_s0), .req_s1(req_s1), .req_s2(req_s2), .req_s3(req_s3),
    .req_ready(req_ready), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));
  ahf_host_model host (.mclk(mclk), .rstn(rstn), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hexc

  task automatic build(input ahf_cmd_type c, input ahf_set_type v);
    logic [7:0] lead[4];
    logic [7:0] sep;
    exp_q.delete();
    if (c == AHF_CMD_BYTE_WAVE) begin
      lead = '{8'h57, 8'h5a, 8'h59, 8'h58};
    end else begin
      lead = '{8'h41, 8'h42, 8'h43, 8'h44};
    end
    sep = (c == AHF_CMD_WORD_BOTH) ? 8'h2c : (c == AHF_CMD_WORD_WAVE) ? 8'h3a : 8'h3d;
    for (int i = 0; i < 4; i++) begin
      if (c == AHF_CMD_BYTE_WAVE || c == AHF_CMD_BYTE_BAR) begin
        exp_q.push_back(lead[i]);
        exp_q.push_back(hexc(v[i][7:4]));
        exp_q.push_back(hexc(v[i][3:0]));
      end else begin
        if (i > 0) exp_q.push_back(sep);
        for (int k = 3; k >= 0; k--) exp_q.push_back(hexc(v[i][4*k +: 4]));
      end
    end
    exp_q.push_back(8'h0d);
    exp_q.push_back(8'h0a);
  endtask : build

  // One command; the request is held up with other data while busy and must be ignored
  task automatic run(input ahf_cmd_type c, input ahf_set_type v);
    int n;
    build(c, v);
    host.rx_q.delete();
    @(posedge mclk);
    req_valid <= 1'b1;
    req_cmd <= c;
    {req_s0, req_s1, req_s2, req_s3} <= {v[0], v[1], v[2], v[3]};
    @(posedge mclk);
    req_cmd <= AHF_CMD_WORD_BAR;
    {req_s0, req_s1, req_s2, req_s3} <= 64'h5555_aaaa_5555_aaaa;
    repeat (4) @(posedge mclk);
    req_valid <= 1'b0;
    @(negedge mclk);
    chk8({7'h0, req_ready}, 8'h00);
    n = 0;
    while (req_ready !== 1'b1 && n < 600) begin
      @(negedge mclk);
      n++;
    end
    chk8({7'h0, req_ready}, 8'h01);
    repeat (3) @(negedge mclk);
    chk8({7'h0, tx_valid}, 8'h00);
    chk8(8'(host.rx_q.size()), 8'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < host.rx_q.size(); i++) begin
      chk8(host.rx_q[i], exp_q[i]);
    end
  endtask : run

  task automatic t_all_cmds;
    ahf_set_type v;
    v = '{16'hf0a5, 16'h1b2c, 16'h3d4e, 16'h96ef};
    run(AHF_CMD_BYTE_WAVE, v);
    run(AHF_CMD_BYTE_BAR, v);
    run(AHF_CMD_WORD_BOTH, v);
    run(AHF_CMD_WORD_WAVE, v);
    run(AHF_CMD_WORD_BAR, v);
  endtask : t_all_cmds

  task automatic t_bounds;
    ahf_set_type v;
    v = '{16'h0000, 16'hffff, 16'h12ff, 16'hab00};
    run(AHF_CMD_BYTE_BAR, v);
    run(AHF_CMD_WORD_WAVE, v);
  endtask : t_bounds

  task automatic t_slow_host;
    ahf_set_type v;
    v = '{16'hcafe, 16'hbeef, 16'h0dd0, 16'h7f7f};
    slow <= 1'b1;
    run(AHF_CMD_WORD_BOTH, v);
    run(AHF_CMD_BYTE_WAVE, v);
    slow <= 1'b0;
  endtask : t_slow_host

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    #(8 * 20000);
    mismatches++;
    final_report();
  end

  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_cmd = AHF_CMD_BYTE_WAVE;
    {req_s0, req_s1, req_s2, req_s3} = 64'h0;
    slow = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    chk8({6'h0, req_ready, tx_valid}, 8'h02);
    t_all_cmds();
    t_bounds();
    t_slow_host();
    final_report();
  end
endmodule : ahf_framer_tb

// file: tb/ahf_host_model.sv
// Host model: a serial grapher that takes one character per ready handshake.
// Assumes the framer holds tx_valid and tx_data until an edge with tx_ready high.
`timescale 1ns/1ps
module ahf_host_model (
  input wire logic mclk,          // System clock
  input wire logic rstn,          // Synchronous reset, active low
  input wire logic slow,          // Stall on alternate edges
  input wire logic tx_valid,      // Character offered
  input wire logic [7:0] tx_data, // ASCII character
  output logic tx_ready           // Character taken at this edge
);
  logic [7:0] rx_q[$];
  logic tog_reg;

  always @(posedge mclk) begin
    if (!rstn) begin
      tog_reg <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      tog_reg <= ~tog_reg;
      // A slow host drops ready on alternate edges, so CR, LF and an unaligned first character wait a second cycle; digits keep their pace
      tx_ready <= slow ? tog_reg : 1'b1;
      if (tx_valid && tx_ready) begin
        rx_q.push_back(tx_data);
      end
    end
  end
endmodule : ahf_host_model
